/* src/tpc_regs.sv */
// Trace power-down control and resource configuration register bank
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_regs (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic [`TPC_ADDR_W-1:0]    awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire tpc_pkg::tpc_word_t        wdata,
    input  wire tpc_pkg::tpc_strb_t        wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [`TPC_ADDR_W-1:0]    araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output tpc_pkg::tpc_word_t             rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    output logic                           tracePowerDownOut,
    output logic                           tracePowerUpOut,
    output tpc_pkg::tpc_word_t             traceMainControl
);

    ////////////////////////////////////////////////////////////////////////
    // Constant configuration code

    tpc_pkg::tpc_word_t cfgCode;

    always_comb begin
        cfgCode = 32'h0000_0000;
        cfgCode[`TPC_CFG_ID_BIT]    = 1'b1;
        cfgCode[`TPC_CFG_SWACC_BIT] = 1'b1;
        cfgCode[`TPC_CFG_SSTOP_BIT] = 1'b1;
        cfgCode[`TPC_CFG_CTXID_LSB +: 2]  = `TPC_CFG_CTXID_VAL;
        cfgCode[`TPC_CFG_STALL_BIT] = `TPC_CFG_STALL_VAL;
        cfgCode[`TPC_CFG_EXTOUT_LSB +: 3] = `TPC_CFG_EXTOUT_VAL;
        cfgCode[`TPC_CFG_EXTIN_LSB +: 3]  = `TPC_CFG_EXTIN_VAL;
        cfgCode[`TPC_CFG_SEQ_BIT]   = 1'b1;
        cfgCode[`TPC_CFG_CNT_LSB +: 3]    = `TPC_CFG_CNT_VAL;
        cfgCode[`TPC_CFG_ADDRCMP_LSB +: 4] = `TPC_CFG_ADDRCMP_VAL;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order

    logic                   awHeld_reg;
    logic                   awHeld_next;
    logic                   wHeld_reg;
    logic                   wHeld_next;
    logic [`TPC_ADDR_W-1:0] wAddr_reg;
    logic [`TPC_ADDR_W-1:0] wAddr_next;
    tpc_pkg::tpc_word_t     wData_reg;
    tpc_pkg::tpc_word_t     wData_next;
    tpc_pkg::tpc_strb_t     wStrb_reg;
    tpc_pkg::tpc_strb_t     wStrb_next;
    logic                   bValid_reg;
    logic                   bValid_next;
    tpc_pkg::tpc_resp_e     bResp_reg;
    tpc_pkg::tpc_resp_e     bResp_next;
    logic                   doWrite;
    logic                   wrHit;

    assign awready = !awHeld_reg && !bValid_reg;
    assign wready  = !wHeld_reg && !bValid_reg;
    assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;

    always_comb begin
        case (wAddr_reg)
            `TPC_OFS_MAIN_CTRL,
            `TPC_OFS_RES_CONFIG,
            `TPC_OFS_OS_LOCK,
            `TPC_OFS_CLAIM_SET,
            `TPC_OFS_CLAIM_CLR,
            `TPC_OFS_LOCK_ACCESS: wrHit = 1'b1;
            default:              wrHit = 1'b0;
        endcase
    end

    always_comb begin
        awHeld_next = awHeld_reg;
        wHeld_next  = wHeld_reg;
        wAddr_next  = wAddr_reg;
        wData_next  = wData_reg;
        wStrb_next  = wStrb_reg;
        bValid_next = bValid_reg;
        bResp_next  = bResp_reg;
        if (awvalid && awready) begin
            awHeld_next = 1'b1;
            wAddr_next  = awaddr;
        end
        if (wvalid && wready) begin
            wHeld_next = 1'b1;
            wData_next = wdata;
            wStrb_next = wstrb;
        end
        if (doWrite) begin
            awHeld_next = 1'b0;
            wHeld_next  = 1'b0;
            bValid_next = 1'b1;
            bResp_next  = wrHit ? tpc_pkg::TPC_RESP_OKAY
                                : tpc_pkg::TPC_RESP_SLVERR;
        end else if (bValid_reg && bready) begin
            bValid_next = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            wAddr_reg  <= '0;
            wData_reg  <= 32'h0000_0000;
            wStrb_reg  <= 4'h0;
            bValid_reg <= 1'b0;
            bResp_reg  <= tpc_pkg::TPC_RESP_OKAY;
        end else begin
            awHeld_reg <= awHeld_next;
            wHeld_reg  <= wHeld_next;
            wAddr_reg  <= wAddr_next;
            wData_reg  <= wData_next;
            wStrb_reg  <= wStrb_next;
            bValid_reg <= bValid_next;
            bResp_reg  <= bResp_next;
        end
    end

    assign bvalid = bValid_reg;
    assign bresp  = bResp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Register state

    tpc_pkg::tpc_word_t     main_reg;
    tpc_pkg::tpc_word_t     main_next;
    tpc_pkg::tpc_word_t     mainMerged;
    tpc_pkg::tpc_word_t     mainMask;
    logic [`TPC_CLAIM_W-1:0] claim_reg;
    logic [`TPC_CLAIM_W-1:0] claim_next;
    logic                   swLock_reg;
    logic                   swLock_next;
    logic                   osLock_reg;
    logic                   osLock_next;

    // A write carrying the power-down bit keeps only bit 0
    assign mainMask = wData_reg[`TPC_MAIN_PD_BIT] && wStrb_reg[0]
                    ? `TPC_MAIN_PD_WMASK : `TPC_MAIN_WMASK;

    tpc_strb_merge #(
        .WIDTH (32)
    ) u_mainMerge (
        .oldVal (main_reg),
        .newVal (wData_reg),
        .strb   (wStrb_reg),
        .wmask  (mainMask),
        .merged (mainMerged)
    );

    always_comb begin
        main_next   = main_reg;
        claim_next  = claim_reg;
        swLock_next = swLock_reg;
        osLock_next = osLock_reg;
        if (doWrite) begin
            case (wAddr_reg)
                `TPC_OFS_MAIN_CTRL:   main_next = mainMerged;
                `TPC_OFS_CLAIM_SET: begin
                    if (wStrb_reg[0]) begin
                        claim_next = claim_reg | wData_reg[7:0];
                    end
                end
                `TPC_OFS_CLAIM_CLR: begin
                    if (wStrb_reg[0]) begin
                        claim_next = claim_reg & ~wData_reg[7:0];
                    end
                end
                `TPC_OFS_LOCK_ACCESS: begin
                    if (wStrb_reg == 4'hf) begin
                        swLock_next = wData_reg != `TPC_LOCK_KEY;
                    end
                end
                `TPC_OFS_OS_LOCK: begin
                    if (wStrb_reg[0]) begin
                        osLock_next = wData_reg[0];
                    end
                end
                default: main_next = main_reg;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            main_reg   <= `TPC_MAIN_RESET;
            claim_reg  <= `TPC_CLAIM_RESET;
            swLock_reg <= `TPC_LOCK_RESET;
            osLock_reg <= `TPC_OSLOCK_RESET;
        end else begin
            main_reg   <= main_next;
            claim_reg  <= claim_next;
            swLock_reg <= swLock_next;
            osLock_reg <= osLock_next;
        end
    end

    // Power controller halts trace clocks while this pin is high
    assign tracePowerDownOut = main_reg[`TPC_MAIN_PD_BIT];
    assign tracePowerUpOut   = !main_reg[`TPC_MAIN_PD_BIT];
    assign traceMainControl  = main_reg;

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data

    logic               rValid_reg;
    logic               rValid_next;
    tpc_pkg::tpc_word_t rData_reg;
    tpc_pkg::tpc_word_t rData_next;
    tpc_pkg::tpc_resp_e rResp_reg;
    tpc_pkg::tpc_resp_e rResp_next;

    assign arready = !rValid_reg;

    always_comb begin
        rValid_next = rValid_reg;
        rData_next  = rData_reg;
        rResp_next  = rResp_reg;
        if (arvalid && arready) begin
            rValid_next = 1'b1;
            rResp_next  = tpc_pkg::TPC_RESP_OKAY;
            case (araddr)
                `TPC_OFS_MAIN_CTRL:    rData_next = main_reg;
                `TPC_OFS_RES_CONFIG:   rData_next = cfgCode;
                `TPC_OFS_CLAIM_SET,
                `TPC_OFS_CLAIM_CLR:    rData_next = {24'h0, claim_reg};
                `TPC_OFS_LOCK_STAT:    rData_next = {30'h0, swLock_reg, 1'b1};
                `TPC_OFS_OS_LOCK_STAT: rData_next = {30'h0, osLock_reg, 1'b0};
                `TPC_OFS_OS_LOCK,
                `TPC_OFS_LOCK_ACCESS:  rData_next = 32'h0000_0000;
                default: begin
                    rData_next = 32'h0000_0000;
                    rResp_next = tpc_pkg::TPC_RESP_SLVERR;
                end
            endcase
        end else if (rValid_reg && rready) begin
            rValid_next = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rValid_reg <= 1'b0;
            rData_reg  <= 32'h0000_0000;
            rResp_reg  <= tpc_pkg::TPC_RESP_OKAY;
        end else begin
            rValid_reg <= rValid_next;
            rData_reg  <= rData_next;
            rResp_reg  <= rResp_next;
        end
    end

    assign rvalid = rValid_reg;
    assign rdata  = rData_reg;
    assign rresp  = rResp_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence seqMainWrite;
        doWrite && wAddr_reg == `TPC_OFS_MAIN_CTRL;
    endsequence

    sequence seqPdWrite;
        seqMainWrite ##0 (wData_reg[0] && wStrb_reg[0]);
    endsequence

    sequence seqCfgRead;
        arvalid && arready && araddr == `TPC_OFS_RES_CONFIG;
    endsequence

    AST_PD_PINS: assert property (
        tracePowerDownOut == main_reg[0] &&
        tracePowerUpOut == !tracePowerDownOut)
        else $error("power pins disagree with control bit 0");

    AST_PD_RESET: assert property (
        $past(rst) |-> main_reg == `TPC_MAIN_RESET)
        else $error("control register reset value wrong");

    AST_PD_WRITE_MASK: assert property (
        seqPdWrite |=> (main_reg & ~32'h0000_0001) ==
                       ($past(main_reg) & ~32'h0000_0001))
        else $error("power-down write changed other bits");

    AST_PD_BIT_WRITE: assert property (
        seqMainWrite ##0 wStrb_reg[0] |=> main_reg[0] == $past(wData_reg[0]))
        else $error("bit 0 write not taken");

    AST_CLAIM_SET: assert property (
        doWrite && wAddr_reg == `TPC_OFS_CLAIM_SET && wStrb_reg[0]
        |=> (claim_reg & $past(wData_reg[7:0])) == $past(wData_reg[7:0]))
        else $error("claim set lost");

    AST_OSLOCK_WRITE: assert property (
        doWrite && wAddr_reg == `TPC_OFS_OS_LOCK && wStrb_reg[0]
        |=> osLock_reg == $past(wData_reg[0]))
        else $error("OS lock write lost");

    AST_CFG_READ: assert property (
        seqCfgRead |=> rvalid && rdata == 32'h8d29_4004 && rresp == 2'b00)
        else $error("configuration code read wrong");

    AST_CFG_READONLY: assert property (
        doWrite && wAddr_reg == `TPC_OFS_RES_CONFIG |=> $stable(main_reg))
        else $error("configuration write had an effect");

    AST_B_HOLD: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");

    AST_R_HOLD: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");

endmodule

/* src/tpc_defines.svh */
// Register offsets, field positions, reset values of the trace power regs
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// Byte addresses on the register bus
`define TPC_OFS_MAIN_CTRL    12'h000
`define TPC_OFS_RES_CONFIG   12'h004
`define TPC_OFS_OS_LOCK      12'h300
`define TPC_OFS_OS_LOCK_STAT 12'h304
`define TPC_OFS_CLAIM_SET    12'hfa0
`define TPC_OFS_CLAIM_CLR    12'hfa4
`define TPC_OFS_LOCK_ACCESS  12'hfb0
`define TPC_OFS_LOCK_STAT    12'hfb4
`define TPC_ADDR_W           12

// Main control register
`define TPC_MAIN_RESET       32'h0000_0401
`define TPC_MAIN_WMASK       32'h7000_d701
`define TPC_MAIN_PD_WMASK    32'h0000_0001
`define TPC_MAIN_PD_BIT      0

// Configuration code fields
`define TPC_CFG_ID_BIT       31
`define TPC_CFG_SWACC_BIT    27
`define TPC_CFG_SSTOP_BIT    26
`define TPC_CFG_CTXID_LSB    24
`define TPC_CFG_CTXID_VAL    2'h1
`define TPC_CFG_STALL_BIT    23
`define TPC_CFG_STALL_VAL    1'h0
`define TPC_CFG_EXTOUT_LSB   20
`define TPC_CFG_EXTOUT_VAL   3'h2
`define TPC_CFG_EXTIN_LSB    17
`define TPC_CFG_EXTIN_VAL    3'h4
`define TPC_CFG_SEQ_BIT      16
`define TPC_CFG_CNT_LSB      13
`define TPC_CFG_CNT_VAL      3'h2
`define TPC_CFG_ADDRCMP_LSB  0
`define TPC_CFG_ADDRCMP_VAL  4'h4

// Claim tags, software lock, OS lock
`define TPC_CLAIM_W          8
`define TPC_CLAIM_RESET      8'h00
`define TPC_LOCK_KEY         32'hc5ac_ce55
`define TPC_LOCK_RESET       1'h1
`define TPC_OSLOCK_RESET     1'h0

`endif

/* src/tpc_pkg.sv */
// Types shared by the trace power and configuration register bank
package tpc_pkg;
    typedef logic [31:0] tpc_word_t;
    typedef logic [3:0]  tpc_strb_t;
    typedef enum logic [1:0] {
        TPC_RESP_OKAY   = 2'b00,
        TPC_RESP_SLVERR = 2'b10
    } tpc_resp_e;
endpackage

/* src/tpc_strb_merge.sv */
// Byte-lane write merge under a writable-bit mask
`timescale 1ns/1ps
module tpc_strb_merge #(
    parameter int WIDTH = 32
) (
    input  wire logic [WIDTH-1:0]   oldVal,
    input  wire logic [WIDTH-1:0]   newVal,
    input  wire logic [WIDTH/8-1:0] strb,
    input  wire logic [WIDTH-1:0]   wmask,
    output logic      [WIDTH-1:0]   merged
);
    logic [WIDTH-1:0] laneMask;

    always_comb begin
        for (int i = 0; i < WIDTH / 8; i++) begin
            laneMask[i*8 +: 8] = {8{strb[i]}};
        end
    end

    assign merged = (oldVal & ~(laneMask & wmask))
                  | (newVal & laneMask & wmask);
endmodule

/* dv/tpc_power_ctrl.sv */
// Behavioural external power controller watching the power-down pin
`timescale 1ns/1ps
module tpc_power_ctrl (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic powerDownIn,
    input  wire logic powerUpIn,
    output logic      traceClkRun
);
    logic runNext;
    // Trace clocks stop whenever power-down is requested
    always_comb begin
        runNext = !powerDownIn && powerUpIn;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            traceClkRun <= 1'b0;
        end else begin
            traceClkRun <= runNext;
        end
    end
endmodule

/* dv/tpc_regs_tb.sv */
// Self-checking bench for the trace power and configuration registers
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_regs_tb;
    localparam tpc_pkg::tpc_word_t CfgExp = 32'h8000_0000 | 32'h0800_0000
        | 32'h0400_0000 | 32'h0100_0000 | 32'h0020_0000 | 32'h0008_0000
        | 32'h0001_0000 | 32'h0000_4000 | 32'h0000_0004;
    logic                mclk = 1'b0;
    logic                rst = 1'b1;
    logic [11:0]         awaddr = 12'h000;
    logic                awvalid = 1'b0;
    logic                awready;
    tpc_pkg::tpc_word_t  wdata = 32'h0;
    tpc_pkg::tpc_strb_t  wstrb = 4'hf;
    logic                wvalid = 1'b0;
    logic                wready;
    logic [1:0]          bresp;
    logic                bvalid;
    logic                bready = 1'b0;
    logic [11:0]         araddr = 12'h000;
    logic                arvalid = 1'b0;
    logic                arready;
    tpc_pkg::tpc_word_t  rdata;
    logic [1:0]          rresp;
    logic                rvalid;
    logic                rready = 1'b0;
    logic                pdOut;
    logic                puOut;
    tpc_pkg::tpc_word_t  mainCtl;
    logic                clkRun;
    int                  numErrors = 0;
    int                  nCompared = 0;
    tpc_pkg::tpc_word_t  rd;
    logic [1:0]          rsp;

    always #5 mclk = ~mclk;

    tpc_regs dut (.mclk(mclk), .rst(rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .tracePowerDownOut(pdOut),
        .tracePowerUpOut(puOut), .traceMainControl(mainCtl));
    tpc_power_ctrl pwr (.mclk(mclk), .rst(rst), .powerDownIn(pdOut),
        .powerUpIn(puOut), .traceClkRun(clkRun));

    ////////////////////////////////////////////////////////////////////////
    task automatic finalReport();
        if (numErrors == 0 && nCompared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chkWord(input tpc_pkg::tpc_word_t g, e);
        nCompared++;
        if (g !== e) begin
            numErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chkResp(input logic [1:0] g, e);
        nCompared++;
        if (g !== e) begin
            numErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chkPins(input logic pd);
        chkWord({30'h0, pdOut, puOut}, {30'h0, pd, !pd});
        chkWord({31'h0, mainCtl[0]}, {31'h0, pd});
        chkWord({31'h0, clkRun}, {31'h0, !pd});
    endtask
    // Write: both channels offered together, each released once taken
    task automatic axiWr(input logic [11:0] a, input tpc_pkg::tpc_word_t d,
                         input logic [1:0] er);
        logic ah;
        logic wh;
        ah = 1'b0;
        wh = 1'b0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Only the watchdog ends a wait on the slave
        while (!(ah && wh)) begin
            @(posedge mclk);
            if (awvalid && awready === 1'b1) begin
                ah = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                wh = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) begin
            @(posedge mclk);
        end
        chkResp(bresp, er);
        bready <= 1'b0;
    endtask
    task automatic axiRd(input logic [11:0] a,
                         output tpc_pkg::tpc_word_t d, output logic [1:0] r);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) begin
            @(posedge mclk);
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdChk(input logic [11:0] a, input tpc_pkg::tpc_word_t e,
                         input tpc_pkg::tpc_word_t m);
        axiRd(a, rd, rsp);
        chkWord(rd & m, e);
        chkResp(rsp, tpc_pkg::TPC_RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        chkPins(1'b1);
        rdChk(`TPC_OFS_MAIN_CTRL, `TPC_MAIN_RESET, 32'hffff_ffff);
    endtask
    task automatic testPowerGate();
        axiWr(`TPC_OFS_MAIN_CTRL, 32'h0, 2'b00);
        @(posedge mclk);
        chkPins(1'b0);
        axiWr(`TPC_OFS_MAIN_CTRL, 32'hffff_ffff, 2'b00);
        rdChk(`TPC_OFS_MAIN_CTRL, 32'h1, 32'hffff_ffff);
        chkPins(1'b1);
        axiWr(`TPC_OFS_MAIN_CTRL, 32'h7000_d700, 2'b00);
        rdChk(`TPC_OFS_MAIN_CTRL, 32'h7000_d700, 32'hffff_ffff);
        chkPins(1'b0);
        axiWr(`TPC_OFS_MAIN_CTRL, 32'h0000_0001, 2'b00);
        rdChk(`TPC_OFS_MAIN_CTRL, 32'h7000_d701, 32'hffff_ffff);
        chkWord(mainCtl, 32'h7000_d701);
    endtask
    task automatic testOtherWrites();
        axiWr(`TPC_OFS_CLAIM_SET, 32'hff, 2'b00);
        axiWr(`TPC_OFS_CLAIM_CLR, 32'h0f, 2'b00);
        rdChk(`TPC_OFS_CLAIM_SET, 32'hf0, 32'hff);
        rdChk(`TPC_OFS_LOCK_STAT, 32'h2, 32'h2);
        axiWr(`TPC_OFS_LOCK_ACCESS, `TPC_LOCK_KEY, 2'b00);
        rdChk(`TPC_OFS_LOCK_STAT, 32'h0, 32'h2);
        axiWr(`TPC_OFS_OS_LOCK, 32'h1, 2'b00);
        rdChk(`TPC_OFS_OS_LOCK_STAT, 32'h2, 32'h2);
    endtask
    task automatic testConfig();
        rdChk(`TPC_OFS_RES_CONFIG, CfgExp, 32'hffff_ffff);
        axiWr(`TPC_OFS_RES_CONFIG, 32'h0, 2'b00);
        rdChk(`TPC_OFS_RES_CONFIG, CfgExp, 32'hffff_ffff);
        rdChk(`TPC_OFS_RES_CONFIG, CfgExp, 32'hffff_ffff);
        rdChk(`TPC_OFS_RES_CONFIG, 32'h0, 32'h7000_1ff0);
        axiRd(12'h0f0, rd, rsp);
        chkResp(rsp, tpc_pkg::TPC_RESP_SLVERR);
        chkWord(rd, 32'h0);
        axiWr(12'h0f0, 32'h1, 2'b10);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        testReset();
        testPowerGate();
        testOtherWrites();
        testConfig();
        // Mid-run reset must keep power-down up and bring the control register back to its reset value
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        testReset();
        repeat (2) @(posedge mclk);
        finalReport();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        numErrors++;
        finalReport();
    end
endmodule
